// ===== kscan_cfg.svh
// Contract
// [RULE_01] Digit strobes pulse low in turn, 320 us.
// [RULE_02] Strobe low time follows the intensity duty.
// [RULE_03] Scan two keys per enabled digit only.
// [RULE_04] Scan loops; full debounce every 41 ms.
// [RULE_05] Newly pressed in both samples raises interrupt.
// [RULE_06] Any key combination detected, no lockout.
// [RULE_07] Port bits 7..5 choose shared pin function.
// [RULE_08] Port bits 4,3 choose sense input modes.
// [RULE_09] Port read returns config, levels, interrupt.
// [RULE_10] Two keyscan inputs eight keys, one four.
// [RULE_11] Debounced bit set since last read.
// [RULE_12] Debounced read clears; otherwise bits accumulate.
// [RULE_13] Debounced read clears pending interrupt.
// [RULE_14] Held key reported once until released.
// [RULE_15] No event queue; host reads each interrupt.
// [RULE_16] Debounced register ignores writes.
// [RULE_17] Pressed bit follows the latest key test.
// [RULE_18] Pressed read has no side effect.
// [RULE_19] Pressed register ignores writes.
// [RULE_20] Scan limit bounds the scanned keys.
// [RULE_21] Bit n of key registers is switch n.
`ifndef KSCAN_CFG_SVH
`define KSCAN_CFG_SVH

`define KS_ADDR_PORT 8'h06
`define KS_ADDR_DEB 8'h08
`define KS_ADDR_PRS 8'h0C

`define KS_CFG_FN_HI 7
`define KS_CFG_FN_LO 5
`define KS_CFG_SEG_BIT 7
`define KS_CFG_MODE_B 4
`define KS_CFG_MODE_A 3
`define KS_CFG_RST 5'h10

`define KS_CLK_MHZ 200
`define KS_STROBE_NOM_US 320
`define KS_SLOT_CYC (`KS_STROBE_NOM_US * `KS_CLK_MHZ)
`define KS_STEPS 64
`define KS_INT_MAX 6'h3F
`define KS_DUTY_MAX 7'h3F
`define KS_DB_HALF 5'h10
`define KS_KEY_B_OFS 3'h4

`endif

// ===== kscan_pkg.sv
`default_nettype none
package kscan_pkg;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kscan_req_s;

	typedef enum logic [2:0] {
		KS_PIN_LOW = 3'b000,
		KS_PIN_HIGH = 3'b001,
		KS_PIN_IRQ_LO = 3'b010,
		KS_PIN_IRQ_HI = 3'b011
	} kscan_pinfn_e;

	typedef enum logic {
		KS_ST_ON = 1'b0,
		KS_ST_BLANK = 1'b1
	} kscan_phase_e;

endpackage
`default_nettype wire

// ===== kscan_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kscan_sync (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Raw pin and filtered level.
	input wire logic i_async,
	output logic o_level
);
	logic ff1_reg, ff2_reg, ff3_reg, level_reg, level_next;

	// A change counts only once the second and third stages agree.
	always_comb begin
		level_next = level_reg;
		if (ff2_reg == ff3_reg) begin
			level_next = ff3_reg;
		end
	end

	// Pins idle high through the pullups, so reset to high.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ff1_reg <= 1'b1;
			ff2_reg <= 1'b1;
			ff3_reg <= 1'b1;
			level_reg <= 1'b1;
		end else begin
			ff1_reg <= i_async;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;
endmodule
`default_nettype wire

// ===== kscan_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "kscan_cfg.svh"
module kscan_top #(
	parameter int unsigned SLOT_CYC = `KS_SLOT_CYC
) (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Register access from the serial engine.
	input wire kscan_pkg::kscan_req_s i_reg_req,
	output logic [7:0] o_reg_rdata,
	// Display settings from the display core.
	input wire logic [5:0] i_intensity,
	input wire logic [1:0] i_scan_limit,
	input wire logic i_seg9_drive,
	// Sense pins.
	input wire logic i_sense_input_a,
	input wire logic i_sense_input_b,
	// Digit strobes and the shared pin.
	output logic [3:0] o_cathode_strobe_n,
	output logic o_shared_irq_segment_pin_o,
	output logic o_shared_irq_segment_pin_oe
);
	localparam int unsigned STEP_RAW = SLOT_CYC / `KS_STEPS;
	localparam int unsigned STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;

	////////////////////////////////////////////////////////////////////
	logic lvl_a, lvl_b;

	kscan_sync u_sync_a (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sense_input_a),
		.o_level(lvl_a)
	);

	kscan_sync u_sync_b (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sense_input_b),
		.o_level(lvl_b)
	);

	////////////////////////////////////////////////////////////////////
	// Multiplex timing: a slot of 64 steps per digit.
	logic [31:0] cnt_reg, cnt_next;
	logic [5:0] step_reg, step_next;
	logic [1:0] digit_reg, digit_next;
	logic [4:0] pass_reg, pass_next;
	kscan_pkg::kscan_phase_e phase_reg, phase_next;
	logic [3:0] strobe_reg, strobe_next;
	logic [6:0] duty;
	logic step_end, sample_ev;

	always_comb begin
		duty = (i_intensity == `KS_INT_MAX) ? `KS_DUTY_MAX :
			{1'b0, i_intensity} + 7'h01; // [RULE_02]
		step_end = (cnt_reg == STEP_CYC - 1);
		sample_ev = step_end && (phase_reg == kscan_pkg::KS_ST_ON) &&
			({1'b0, step_reg} == duty - 7'h01);
		cnt_next = step_end ? 32'h0 : cnt_reg + 32'h1;
		step_next = step_reg;
		digit_next = digit_reg;
		pass_next = pass_reg;
		phase_next = phase_reg;
		if (step_end) begin
			step_next = step_reg + 6'h01;
			if ({1'b0, step_next} >= duty) begin
				phase_next = kscan_pkg::KS_ST_BLANK;
			end
			if (step_reg == 6'h3F) begin
				phase_next = kscan_pkg::KS_ST_ON;
				// Only digits up to the scan limit are strobed.
				if (digit_reg >= i_scan_limit) begin // [RULE_03] [RULE_20]
					digit_next = 2'h0;
					pass_next = pass_reg + 5'h01; // [RULE_04]
				end else begin
					digit_next = digit_reg + 2'h1; // [RULE_01]
				end
			end
		end
		strobe_next = 4'hF;
		// A lowered scan limit blanks a digit above it at once, not at slot end.
		if (phase_next == kscan_pkg::KS_ST_ON &&
			digit_next <= i_scan_limit) begin // [RULE_20]
			strobe_next = ~(4'h1 << digit_next); // [RULE_01]
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 32'h0;
			step_reg <= 6'h00;
			digit_reg <= 2'h0;
			pass_reg <= 5'h00;
			phase_reg <= kscan_pkg::KS_ST_ON;
			strobe_reg <= 4'hF;
		end else begin
			cnt_reg <= cnt_next;
			step_reg <= step_next;
			digit_reg <= digit_next;
			pass_reg <= pass_next;
			phase_reg <= phase_next;
			strobe_reg <= strobe_next;
		end
	end

	assign o_cathode_strobe_n = strobe_reg;

	////////////////////////////////////////////////////////////////////
	// Key tests. Digit d serves switch d on input a, d+4 on input b.
	logic [7:3] cfg_reg, cfg_next;
	logic [7:0] first_reg, first_next;
	logic [7:0] held_reg, held_next;
	logic [7:0] prs_reg, prs_next;
	logic [7:0] deb_reg, deb_next;
	logic [7:0] new_deb;
	logic irq_reg, irq_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [2:0] ka, kb;
	logic pa, pb;
	logic rd_deb, rd_prs;

	always_comb begin
		ka = {1'b0, digit_reg}; // [RULE_21]
		kb = ka + `KS_KEY_B_OFS;
		// A closed key pulls its sense pin low through the strobe.
		pa = cfg_reg[`KS_CFG_MODE_A] & ~lvl_a; // [RULE_10]
		pb = cfg_reg[`KS_CFG_MODE_B] & ~lvl_b; // [RULE_10]
		first_next = first_reg;
		held_next = held_reg;
		prs_next = prs_reg;
		new_deb = 8'h00;
		if (sample_ev) begin
			prs_next[ka] = pa; // [RULE_17]
			prs_next[kb] = pb; // [RULE_17]
			if (pass_reg == 5'h00) begin
				first_next[ka] = pa;
				first_next[kb] = pb;
			end
			if (pass_reg == `KS_DB_HALF) begin
				// Keys are judged independently, so no key masks another.
				new_deb[ka] = first_reg[ka] & pa & ~held_reg[ka]; // [RULE_05] [RULE_06] [RULE_14]
				new_deb[kb] = first_reg[kb] & pb & ~held_reg[kb]; // [RULE_05] [RULE_06] [RULE_14]
				held_next[ka] = (first_reg[ka] & pa) | (held_reg[ka] & pa); // [RULE_14]
				held_next[kb] = (first_reg[kb] & pb) | (held_reg[kb] & pb); // [RULE_14]
			end
		end
		// Keys past the scan limit are never strobed, so drop them.
		for (int i = 0; i < 4; i++) begin
			if (i > int'(i_scan_limit)) begin
				prs_next[i] = 1'b0; // [RULE_20]
				prs_next[i + 4] = 1'b0; // [RULE_20]
				held_next[i] = 1'b0;
				held_next[i + 4] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register access. Reads answer one cycle after the strobe.
	always_comb begin
		rd_deb = i_reg_req.rd && (i_reg_req.addr == `KS_ADDR_DEB);
		rd_prs = i_reg_req.rd && (i_reg_req.addr == `KS_ADDR_PRS);
		cfg_next = cfg_reg;
		if (i_reg_req.wr && (i_reg_req.addr == `KS_ADDR_PORT)) begin
			cfg_next = i_reg_req.wdata[7:3]; // [RULE_07] [RULE_08]
		end
		// Writes to the key registers fall through: no case for them.
		// A new event in the read cycle survives the clear.
		deb_next = (rd_deb ? 8'h00 : deb_reg) | new_deb; // [RULE_11] [RULE_12] [RULE_16] [RULE_19]
		irq_next = (rd_deb ? 1'b0 : irq_reg) | (|new_deb); // [RULE_05] [RULE_13]
		rdata_next = rdata_reg;
		if (i_reg_req.rd) begin
			unique case (i_reg_req.addr)
				`KS_ADDR_PORT: rdata_next = {cfg_reg, lvl_b, lvl_a, irq_reg}; // [RULE_09]
				`KS_ADDR_DEB: rdata_next = deb_reg; // [RULE_12] [RULE_15]
				`KS_ADDR_PRS: rdata_next = prs_reg; // [RULE_18]
				default: rdata_next = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared pin: open drain for logic and interrupt, push-pull segment.
	logic pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
	kscan_pkg::kscan_pinfn_e fn;

	always_comb begin
		fn = kscan_pkg::kscan_pinfn_e'(cfg_reg[`KS_CFG_FN_HI:`KS_CFG_FN_LO]);
		pin_o_next = 1'b0;
		pin_oe_next = 1'b0;
		if (cfg_reg[`KS_CFG_SEG_BIT]) begin
			pin_o_next = i_seg9_drive; // [RULE_07]
			pin_oe_next = 1'b1;
		end else begin
			unique case (fn)
				kscan_pkg::KS_PIN_LOW: pin_oe_next = 1'b1; // [RULE_07]
				kscan_pkg::KS_PIN_HIGH: pin_oe_next = 1'b0; // [RULE_07]
				kscan_pkg::KS_PIN_IRQ_LO: pin_oe_next = irq_next; // [RULE_07]
				kscan_pkg::KS_PIN_IRQ_HI: pin_oe_next = ~irq_next; // [RULE_07]
				default: pin_oe_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_reg <= `KS_CFG_RST;
			first_reg <= 8'h00;
			held_reg <= 8'h00;
			prs_reg <= 8'h00;
			deb_reg <= 8'h00;
			irq_reg <= 1'b0;
			rdata_reg <= 8'h00;
			pin_o_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			first_reg <= first_next;
			held_reg <= held_next;
			prs_reg <= prs_next;
			deb_reg <= deb_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
			pin_o_reg <= pin_o_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_shared_irq_segment_pin_o = pin_o_reg;
	assign o_shared_irq_segment_pin_oe = pin_oe_reg;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	property p_one_strobe;
		$countones(~o_cathode_strobe_n) <= 1;
	endproperty
	a_one_strobe: assert property (p_one_strobe) // [RULE_01]
		else $error("More than one strobe low.");

	property p_strobe_limit;
		$stable(i_scan_limit) [*2] |->
			((~o_cathode_strobe_n) >> i_scan_limit) <= 4'h1;
	endproperty
	a_strobe_limit: assert property (p_strobe_limit) // [RULE_03]
		else $error("Strobe beyond scan limit.");

	property p_deb_clear;
		rd_deb && new_deb == 8'h00 |=> deb_reg == 8'h00 && !irq_reg;
	endproperty
	a_deb_clear: assert property (p_deb_clear) // [RULE_12]
		else $error("Debounced read did not clear.");

	property p_irq_pin_clear;
		rd_deb && new_deb == 8'h00 && !cfg_reg[`KS_CFG_SEG_BIT] &&
			fn == kscan_pkg::KS_PIN_IRQ_LO && $stable(cfg_reg) |=>
			!o_shared_irq_segment_pin_oe;
	endproperty
	a_irq_pin_clear: assert property (p_irq_pin_clear) // [RULE_13]
		else $error("Interrupt pin still active after read.");

	property p_deb_set;
		new_deb != 8'h00 |=> (deb_reg & $past(new_deb)) == $past(new_deb)
			&& irq_reg;
	endproperty
	a_deb_set: assert property (p_deb_set) // [RULE_11]
		else $error("Debounced event lost.");

	property p_prs_no_effect;
		rd_prs && new_deb == 8'h00 |=> $stable(deb_reg) && $stable(irq_reg);
	endproperty
	a_prs_no_effect: assert property (p_prs_no_effect) // [RULE_18]
		else $error("Pressed read changed state.");

	property p_wr_ignored;
		i_reg_req.wr && !i_reg_req.rd && !sample_ev &&
			(i_reg_req.addr == `KS_ADDR_DEB ||
			i_reg_req.addr == `KS_ADDR_PRS) |=>
			$stable(deb_reg) && $stable(prs_reg);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) // [RULE_16]
		else $error("Write changed a key register.");

	property p_held_once;
		new_deb != 8'h00 |=> (held_reg & $past(new_deb)) == $past(new_deb);
	endproperty
	a_held_once: assert property (p_held_once) // [RULE_14]
		else $error("Held key reported twice.");

	property p_mode_mask;
		!cfg_reg[`KS_CFG_MODE_A] |-> new_deb[3:0] == 4'h0;
	endproperty
	a_mode_mask: assert property (p_mode_mask) // [RULE_10]
		else $error("Key on logic input debounced.");

	property p_pin_irq_hi;
		!cfg_reg[`KS_CFG_SEG_BIT] && fn == kscan_pkg::KS_PIN_IRQ_HI |=>
			o_shared_irq_segment_pin_oe == !irq_reg;
	endproperty
	a_pin_irq_hi: assert property (p_pin_irq_hi) // [RULE_07]
		else $error("Active-high interrupt pin wrong.");

	c_debounce: cover property (new_deb != 8'h00);
	c_two_keys: cover property ($countones(new_deb) == 2);
	c_read_clear: cover property (rd_deb && irq_reg);
	c_set_on_clear: cover property (rd_deb && new_deb != 8'h00);
endmodule
`default_nettype wire

// ===== kscan_keypad_model.sv
`timescale 1ns/1ps
`default_nettype none
module kscan_keypad_model (
	// Strobes, closed keys and forced line levels.
	input wire logic [3:0] i_strobe_n,
	input wire logic [7:0] i_keys,
	input wire logic [1:0] i_pull_low,
	// Sense lines, pulled up when nothing pulls them low.
	output logic o_sense_a,
	output logic o_sense_b
);
	// Diodes isolate the keys, so a line falls only under its own strobe.
	assign o_sense_a = ~(i_pull_low[0] | |(i_keys[3:0] & ~i_strobe_n));
	assign o_sense_b = ~(i_pull_low[1] | |(i_keys[7:4] & ~i_strobe_n));
endmodule
`default_nettype wire

// ===== tb_keyscan_port_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_keyscan_port_controller;
	// A short slot keeps each full debounce loop near eight thousand cycles.
	localparam int SLOT = 64;
	logic i_sys_clk = 1'b0;
	logic i_nrst = 1'b0;
	kscan_pkg::kscan_req_s req = '0;
	logic [7:0] rdata;
	logic [5:0] inten = 6'h3F;
	logic [1:0] lim = 2'h3;
	logic [7:0] keys = 8'h00;
	logic [1:0] pull = 2'h0;
	logic seg = 1'b0;
	logic sa, sb, pin_o, pin_oe, pin_lvl;
	logic [3:0] strb_n;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2.5 i_sys_clk = ~i_sys_clk;
	// Open-drain pin with a pull-up.
	assign pin_lvl = pin_oe ? pin_o : 1'b1;
	kscan_top #(.SLOT_CYC(SLOT)) u_dut (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_req(req),
		.o_reg_rdata(rdata), .i_intensity(inten), .i_scan_limit(lim),
		.i_seg9_drive(seg), .i_sense_input_a(sa), .i_sense_input_b(sb),
		.o_cathode_strobe_n(strb_n), .o_shared_irq_segment_pin_o(pin_o),
		.o_shared_irq_segment_pin_oe(pin_oe)
	);
	kscan_keypad_model u_keys (
		.i_strobe_n(strb_n), .i_keys(keys), .i_pull_low(pull),
		.o_sense_a(sa), .o_sense_b(sb)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
		req.rd = r;
		req.wr = ~r;
		req.addr = a;
		req.wdata = d;
		@(negedge i_sys_clk);
		req = '0;
		@(negedge i_sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string w);
		acc(1'b1, a, 8'h00);
		chk(w, rdata, exp);
	endtask
	task automatic wait_pin(input logic lv, input int n, output logic hit);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			@(negedge i_sys_clk);
			hit = (pin_lvl === lv);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("strobe", {4'h0, strb_n}, 8'h0E);
		repeat (6) @(negedge i_sys_clk);
		rd(8'h06, 8'h86, "port reset");
		rd(8'h08, 8'h00, "debounced reset");
		rd(8'h0C, 8'h00, "pressed reset");
		chk("segment low", {6'h0, pin_oe, pin_o}, 8'h02);
		seg = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		chk("segment high", {6'h0, pin_oe, pin_o}, 8'h03);
		seg = 1'b0;
		$display("test reset done");
	endtask
	task automatic t_port();
		for (int f = 0; f < 4; f++) begin
			acc(1'b0, 8'h06, {3'(f), 5'h00});
			pull = 2'(f);
			repeat (6) @(negedge i_sys_clk);
			rd(8'h06, {3'(f), 2'b00, ~pull, 1'b0}, "port");
			chk("pin", {7'h0, pin_lvl}, {7'h0, f == 1 || f == 2});
		end
		pull = 2'h0;
		// The sense filter needs a few cycles before the levels read high.
		repeat (6) @(negedge i_sys_clk);
		acc(1'b0, 8'h06, 8'h18);
		rd(8'h06, 8'h1E, "modes");
		acc(1'b0, 8'h08, 8'hFF);
		rd(8'h08, 8'h00, "deb write");
		acc(1'b0, 8'h0C, 8'hFF);
		rd(8'h0C, 8'h00, "prs write");
		rd(8'h07, 8'h00, "unmapped");
		$display("test port done");
	endtask
	task automatic t_strobe();
		int lo;
		logic [5:0] code [4] = '{6'h00, 6'h1F, 6'h3E, 6'h3F};
		int exp [4] = '{1, 32, 63, 63};
		for (int k = 0; k < 4; k++) begin
			inten = code[k];
			@(negedge strb_n[0]);
			@(negedge strb_n[0]);
			lo = 0;
			@(negedge i_sys_clk);
			while (strb_n[0] === 1'b0) begin
				lo++;
				@(negedge i_sys_clk);
			end
			chk("low time", 8'(lo), 8'(exp[k] * SLOT / 64));
			wait (strb_n !== 4'hF);
			@(negedge i_sys_clk);
			chk("next digit", {4'h0, strb_n}, 8'h0D);
		end
		inten = 6'h3F;
		$display("test strobe done");
	endtask
	task automatic t_keys();
		logic hit;
		acc(1'b0, 8'h06, 8'h58);
		// Press inside a digit 0 slot so both keys get their first sample in one pass.
		@(negedge strb_n[0]);
		@(negedge i_sys_clk);
		keys = 8'h21;
		wait_pin(1'b0, 20000, hit);
		chk("irq", {7'h0, hit}, 8'h01);
		// Switch 5 is judged one slot after switch 0.
		repeat (2 * SLOT) @(negedge i_sys_clk);
		rd(8'h0C, 8'h21, "pressed");
		chk("irq kept", {7'h0, pin_lvl}, 8'h00);
		rd(8'h08, 8'h21, "debounced");
		chk("irq clear", {7'h0, pin_lvl}, 8'h01);
		rd(8'h08, 8'h00, "cleared");
		wait_pin(1'b0, 9000, hit);
		chk("no repeat", {7'h0, hit}, 8'h00);
		keys = 8'h02;
		wait_pin(1'b0, 20000, hit);
		chk("irq again", {7'h0, hit}, 8'h01);
		keys = 8'h0A;
		repeat (17000) @(negedge i_sys_clk);
		rd(8'h08, 8'h0A, "accumulate");
		$display("test keys done");
	endtask
	task automatic t_limit();
		logic hit;
		lim = 2'h1;
		acc(1'b0, 8'h06, 8'h48);
		acc(1'b1, 8'h08, 8'h00);
		keys = 8'h11;
		wait_pin(1'b0, 9000, hit);
		repeat (4200) @(negedge i_sys_clk);
		rd(8'h08, 8'h01, "one input");
		lim = 2'h0;
		acc(1'b0, 8'h06, 8'h58);
		keys = 8'h12;
		wait_pin(1'b0, 5000, hit);
		repeat (2100) @(negedge i_sys_clk);
		rd(8'h08, 8'h10, "limit deb");
		rd(8'h0C, 8'h10, "limit prs");
		hit = 1'b0;
		repeat (300) begin
			@(negedge i_sys_clk);
			hit = hit | (strb_n[3:1] !== 3'h7);
		end
		chk("idle digits", {7'h0, hit}, 8'h00);
		$display("test limit done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge i_sys_clk);
		i_nrst = 1'b1;
		@(negedge i_sys_clk);
		t_reset();
		t_port();
		t_strobe();
		t_keys();
		t_limit();
		print_verdict();
	end
endmodule
`default_nettype wire
